// ---- hw/lcr_cell.sv ----
// Purpose: Logic cell whose two function generators serve as small RAM
// Assumes: Mode, timing and logic table are static configuration inputs
// Notes:   All user inputs are fabric logic on clk_i, so none is
//          synchronised; reads never wait for a clock edge
//
// How it works
// - Dual 16-deep mode: two separate one-bit arrays, own data each.
// - 32-deep mode merges both generators into one one-bit array.
// - One generator may be RAM while the other is a 5-input function.
// - Edge timing writes only at the clock edge, enable qualifies it.
// - One timing select governs both generators together.
// - Single port: each generator reads and writes at one address.
// - Dual port: one write port, two read ports, simultaneous access.
// - Read addresses and output selection differ by mode, as writes do.
// - Reads are combinational from the address lines.
// - Four generator inputs form the address into its 16 entries.
// - Data-in, aux and set/reset inputs become data and write enable.
// - 32-deep: second data input is address bit four, first is data.
// - 32-deep: both generators see identical address inputs.
// - Generator outputs leave directly or through the cell flops.

`timescale 1ns/1ns
`default_nettype none

module lcr_cell
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // Configuration
   input  wire lcr_pkg::lcr_mode_e mode_i,
   input  wire logic              level_mode_i,
   input  wire logic [31:0]       logic_table_i,
   // Generator address inputs
   input  wire logic [3:0]        first_gen_addr_i,
   input  wire logic [3:0]        second_gen_addr_i,
   // Control inputs of the cell
   input  wire logic              cell_data_in_aux2_i,
   input  wire logic              cell_aux1_input_i,
   input  wire logic              cell_setreset_aux0_i,
   // Combinational outputs
   output logic                   x_comb_o,
   output logic                   y_comb_o,
   // Registered outputs
   output logic                   x_reg_o,
   output logic                   y_reg_o
);

   // ---------------------------------------------------------------
   // Control inputs take their memory meaning
   // ---------------------------------------------------------------
   logic mem_wdata_lo;
   logic mem_wdata_hi_or_addr4;
   logic mem_we;
   logic level_eff;

   // Data in, aux one and set/reset become low data, high data, enable
   assign mem_wdata_lo          = cell_data_in_aux2_i;
   assign mem_wdata_hi_or_addr4 = cell_aux1_input_i;
   assign mem_we                = cell_setreset_aux0_i;

   // One timing select for both halves; dual port is edge only,
   // since a second port reading during a level write has no order
   assign level_eff = level_mode_i &&
                      (mode_i != lcr_pkg::LCR_DUALPORT);

   // ---------------------------------------------------------------
   // Per-generator address, data and enable steering
   // ---------------------------------------------------------------
   logic [3:0] f_waddr;
   logic [3:0] f_raddr;
   logic       f_wdata;
   logic       f_we;
   logic [3:0] g_waddr;
   logic [3:0] g_raddr;
   logic       g_wdata;
   logic       g_we;

   always_comb
   begin
      // First generator: one address for read and write
      f_waddr = first_gen_addr_i;
      f_raddr = first_gen_addr_i;
      f_wdata = mem_wdata_lo;
      f_we    = mem_we;
      g_waddr = second_gen_addr_i;
      g_raddr = second_gen_addr_i;
      g_wdata = mem_wdata_hi_or_addr4;
      g_we    = mem_we;
      case (mode_i)
         lcr_pkg::LCR_DUAL16:
         begin
            // Two independent arrays, own data and address
            g_we = mem_we;
         end
         lcr_pkg::LCR_WIDE32:
         begin
            // Bit four picks the half that takes the write
            f_we    = mem_we && !mem_wdata_hi_or_addr4;
            g_we    = mem_we && mem_wdata_hi_or_addr4;
            g_waddr = first_gen_addr_i;
            g_raddr = first_gen_addr_i;
            g_wdata = mem_wdata_lo;
         end
         lcr_pkg::LCR_DUALPORT:
         begin
            // Both copies written alike, second copy read elsewhere
            g_waddr = first_gen_addr_i;
            g_raddr = second_gen_addr_i;
            g_wdata = mem_wdata_lo;
            g_we    = mem_we;
         end
         lcr_pkg::LCR_RAM_LOGIC:
         begin
            // Second generator is logic, never written
            g_we = 1'b0;
         end
         default:
         begin
            f_we = 1'b0;
            g_we = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // The two function generators
   // ---------------------------------------------------------------
   logic f_rdata;
   logic g_rdata;

   // Edge write when level_eff is low, enable qualifies the edge
   lcr_lut16 u_first_gen
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .waddr_i (f_waddr),
      .wdata_i (f_wdata),
      .we_i    (f_we),
      .level_i (level_eff),
      .raddr_i (f_raddr),
      .rdata_o (f_rdata)
   );

   lcr_lut16 u_second_gen
   (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .waddr_i (g_waddr),
      .wdata_i (g_wdata),
      .we_i    (g_we),
      .level_i (level_eff),
      .raddr_i (g_raddr),
      .rdata_o (g_rdata)
   );

   // ---------------------------------------------------------------
   // Generator outputs and the combinational exits
   // ---------------------------------------------------------------
   logic g_out;
   logic logic_fn;

   // Five-input function from the table: aux one is the top bit
   assign logic_fn = logic_table_i[{cell_aux1_input_i,
                                    second_gen_addr_i}];

   // The mode picks what each exit carries; no clock is involved
   always_comb
   begin
      g_out    = g_rdata;
      x_comb_o = f_rdata;
      case (mode_i)
         lcr_pkg::LCR_WIDE32:
         begin
            x_comb_o = mem_wdata_hi_or_addr4 ? g_rdata : f_rdata;
         end
         lcr_pkg::LCR_RAM_LOGIC:
         begin
            g_out = logic_fn;
         end
         default:
         begin
            x_comb_o = f_rdata;
         end
      endcase
      y_comb_o = g_out;
   end

   // ---------------------------------------------------------------
   // Cell flip-flops, untouched by the memory configuration
   // ---------------------------------------------------------------
   logic x_reg_q;
   logic x_reg_d;
   logic y_reg_q;
   logic y_reg_d;

   // Capture whatever the exits carry, every edge
   always_comb
   begin
      x_reg_d = x_comb_o;
      y_reg_d = y_comb_o;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         x_reg_q <= lcr_pkg::LCR_FF_RST;
         y_reg_q <= lcr_pkg::LCR_FF_RST;
      end
      else
      begin
         x_reg_q <= x_reg_d;
         y_reg_q <= y_reg_d;
      end
   end

   assign x_reg_o = x_reg_q;
   assign y_reg_o = y_reg_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Edge write to the first array is read back after the edge
   property p_dual_f_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_DUAL16 && !level_mode_i && mem_we) |=>
      ($stable(first_gen_addr_i) ? x_comb_o == $past(mem_wdata_lo) : 1'b1);
   endproperty
   a_dual_f_write: assert property (p_dual_f_write)
      else $error("first array lost an edge write");

   // Second array takes D1 independently
   property p_dual_g_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_DUAL16 && !level_mode_i && mem_we) |=>
      ($stable(second_gen_addr_i) ?
       y_comb_o == $past(mem_wdata_hi_or_addr4) : 1'b1);
   endproperty
   a_dual_g_write: assert property (p_dual_g_write)
      else $error("second array lost its own data");

   // Idle edge mode keeps the read stable at a held address; level
   // mode is left out since a strobe shows its data at once
   property p_no_write_stable;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_DUAL16 && !level_mode_i && !mem_we) ##1
      ($stable(first_gen_addr_i) && $stable(mode_i)) |->
      $stable(x_comb_o);
   endproperty
   a_no_write_stable: assert property (p_no_write_stable)
      else $error("array changed without a write");

   // Level strobe shows the data in the same cycle
   property p_level_through;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_DUAL16 && level_mode_i && mem_we) |->
      x_comb_o == mem_wdata_lo;
   endproperty
   a_level_through: assert property (p_level_through)
      else $error("level write not visible at once");

   // Deep mode write is read back from the half that bit four picks
   property p_wide_write;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_WIDE32 && !level_mode_i && mem_we) |=>
      (($stable(first_gen_addr_i) && $stable(mem_wdata_hi_or_addr4)) ?
       x_comb_o == $past(mem_wdata_lo) : 1'b1);
   endproperty
   a_wide_write: assert property (p_wide_write)
      else $error("deep array lost a write");

   // Deep mode upper half, read at the first address, takes a write
   // only when bit four is high and keeps its bit otherwise
   property p_wide_upper;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_WIDE32 && !level_mode_i && mem_we) |=>
      ($stable(first_gen_addr_i) ?
       y_comb_o == ($past(mem_wdata_hi_or_addr4) ?
                    $past(mem_wdata_lo) : $past(y_comb_o)) : 1'b1);
   endproperty
   a_wide_upper: assert property (p_wide_upper)
      else $error("deep array upper half wrong");

   // Dual port: second read port sees the first port's write
   property p_dp_mirror;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_DUALPORT && mem_we) |=>
      ((second_gen_addr_i == $past(first_gen_addr_i) &&
        $stable(mode_i)) ? y_comb_o == $past(mem_wdata_lo) : 1'b1);
   endproperty
   a_dp_mirror: assert property (p_dp_mirror)
      else $error("second read port missed the write");

   // Logic half follows its table
   property p_logic_fn;
      @(posedge clk_i) disable iff (!rst_n_i)
      (mode_i == lcr_pkg::LCR_RAM_LOGIC) |->
      y_comb_o == logic_table_i[{cell_aux1_input_i, second_gen_addr_i}];
   endproperty
   a_logic_fn: assert property (p_logic_fn)
      else $error("logic function output wrong");

   // Cell flops capture the exits one edge later
   property p_flops;
      @(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> (x_reg_o == $past(x_comb_o) && y_reg_o == $past(y_comb_o));
   endproperty
   a_flops: assert property (p_flops)
      else $error("cell flops did not capture outputs");

endmodule : lcr_cell

`default_nettype wire

// ---- hw/lcr_lut16.sv ----
// Purpose: One 16x1 look-up table used as a writable memory
// Assumes: Write address, data and enable come from the same clock domain
// Notes:   Level mode passes write data straight to the read output

`timescale 1ns/1ns
`default_nettype none

module lcr_lut16
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Write side
   input  wire logic [3:0] waddr_i,
   input  wire logic       wdata_i,
   input  wire logic       we_i,
   input  wire logic       level_i,
   // Read side
   input  wire logic [3:0] raddr_i,
   output logic            rdata_o
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [15:0] mem_q;
   logic [15:0] mem_d;

   // Next contents: one bit replaced while enabled
   always_comb
   begin
      mem_d = mem_q;
      if (we_i)
      begin
         mem_d[waddr_i] = wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         mem_q <= lcr_pkg::LCR_MEM_RST;
      end
      else
      begin
         mem_q <= mem_d;
      end
   end

   // ---------------------------------------------------------------
   // Combinational read, no clock in the path
   // ---------------------------------------------------------------
   // Level mode: strobe high makes the new bit visible at once,
   // as a transparent write would; edge mode shows it after the edge.
   always_comb
   begin
      if (level_i && we_i && (waddr_i == raddr_i))
      begin
         rdata_o = wdata_i;
      end
      else
      begin
         rdata_o = lcr_pkg::lcr_pick16(mem_q, raddr_i);
      end
   end

endmodule : lcr_lut16

`default_nettype wire

// ---- hw/lcr_pkg.sv ----
// Purpose: Shared constants and types for the logic cell memory block
// Assumes: Mode and timing selects are static configuration inputs
// Notes:   Reset values apply to both look-up tables and the cell flops

package lcr_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int unsigned LCR_ADDR_W  = 4;
   localparam int unsigned LCR_DEPTH   = 16;
   localparam int unsigned LCR_TABLE_W = 32;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] LCR_MEM_RST = 16'h0000;
   localparam logic        LCR_FF_RST  = 1'h0;

   // ---------------------------------------------------------------
   // Memory arrangements of one cell
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      LCR_DUAL16,
      LCR_WIDE32,
      LCR_DUALPORT,
      LCR_RAM_LOGIC
   } lcr_mode_e;

   // Pick one entry of a 16-entry table
   function automatic logic lcr_pick16(input logic [15:0] tbl,
                                       input logic [3:0]  addr);
      lcr_pick16 = tbl[addr];
   endfunction : lcr_pick16

endpackage : lcr_pkg

// ---- tb/lcr_fab_model.sv ----
// Purpose: Fabric logic that drives the cell memory inputs
// Assumes: Caller steps it once per clock cycle
// Notes:   Changes land at the falling edge, clear of the sampling edge

`timescale 1ns/1ns
`default_nettype none

module lcr_fab_model
(
   // Clock
   input  wire logic  clk_i,
   // Cell inputs owned by the fabric
   output logic [3:0] faddr_o,
   output logic [3:0] saddr_o,
   output logic       wlo_o,
   output logic       whi_o,
   output logic       we_o
);
   // ---------------------------------------------------------------
   // Idle values at time zero
   // ---------------------------------------------------------------
   initial
   begin
      faddr_o = 4'h0;
      saddr_o = 4'h0;
      wlo_o   = 1'h0;
      whi_o   = 1'h0;
      we_o    = 1'h0;
   end

   // One cycle of stimulus; strobe held the whole cycle so a
   // level write sees a steady pulse across the edge
   task automatic drive(input logic [3:0] fa, input logic [3:0] sa,
                        input logic lo, input logic hi, input logic we);
      @(negedge clk_i);
      faddr_o = fa;
      saddr_o = sa;
      wlo_o   = lo;
      whi_o   = hi;
      we_o    = we;
      #2;
   endtask : drive
endmodule : lcr_fab_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the logic cell memory
// Assumes: Mode changes are followed by a fresh reset
// Notes:   Every scenario judges read data a few ns after the change

`timescale 1ns/1ns
`default_nettype none

module tb_top;
   logic               clk_i;
   logic               rst_n_i;
   lcr_pkg::lcr_mode_e mode_i;
   logic               level_mode_i;
   logic [31:0]        logic_table_i;
   logic [3:0]         fa;
   logic [3:0]         sa;
   logic               wlo;
   logic               whi;
   logic               we;
   logic               x_comb;
   logic               y_comb;
   logic               x_reg;
   logic               y_reg;
   int                 n_mismatch;
   int                 num_checks;
   int                 cyc;

   // ---------------------------------------------------------------
   // Clock, fabric model and design
   // ---------------------------------------------------------------
   initial
   begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end

   lcr_fab_model fab_u (.clk_i(clk_i), .faddr_o(fa), .saddr_o(sa),
                        .wlo_o(wlo), .whi_o(whi), .we_o(we));

   lcr_cell dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode_i),
                   .level_mode_i(level_mode_i),
                   .logic_table_i(logic_table_i),
                   .first_gen_addr_i(fa), .second_gen_addr_i(sa),
                   .cell_data_in_aux2_i(wlo), .cell_aux1_input_i(whi),
                   .cell_setreset_aux0_i(we), .x_comb_o(x_comb),
                   .y_comb_o(y_comb), .x_reg_o(x_reg), .y_reg_o(y_reg));

   // ---------------------------------------------------------------
   // Checking and closing
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
         n_mismatch++;
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   // Hang guard: the whole run needs under a hundred cycles
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 1000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   // Static mode is only changed under reset, three cycles long
   task automatic setup(input lcr_pkg::lcr_mode_e m, input logic lvl);
      @(negedge clk_i);
      mode_i       = m;
      level_mode_i = lvl;
      rst_n_i      = 1'h0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'h1;
   endtask : setup

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_dual16();
      setup(lcr_pkg::LCR_DUAL16, 1'h0);
      chk("x_reg", 1'h0, x_reg);
      fab_u.drive(4'h3, 4'hc, 1'h1, 1'h1, 1'h1);
      chk("x_comb", 1'h0, x_comb);
      fab_u.drive(4'h3, 4'hc, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h1, x_comb);
      chk("y_comb", 1'h1, y_comb);
      fab_u.drive(4'hc, 4'h3, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h0, x_comb);
      chk("y_comb", 1'h0, y_comb);
      fab_u.drive(4'h3, 4'hc, 1'h0, 1'h0, 1'h0);
      @(posedge clk_i);
      #2;
      chk("x_reg", 1'h1, x_reg);
      chk("y_reg", 1'h1, y_reg);
      fab_u.drive(4'h5, 4'h5, 1'h1, 1'h1, 1'h0);
      fab_u.drive(4'h5, 4'h5, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h0, x_comb);
      chk("y_comb", 1'h0, y_comb);
   endtask : t_dual16

   task automatic t_wide32();
      setup(lcr_pkg::LCR_WIDE32, 1'h0);
      fab_u.drive(4'h5, 4'h9, 1'h1, 1'h1, 1'h1);
      fab_u.drive(4'h5, 4'h9, 1'h0, 1'h1, 1'h0);
      chk("x_comb", 1'h1, x_comb);
      fab_u.drive(4'h5, 4'h9, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h0, x_comb);
      fab_u.drive(4'h5, 4'h0, 1'h0, 1'h1, 1'h0);
      chk("x_comb", 1'h1, x_comb);
   endtask : t_wide32

   task automatic t_dualport();
      // Level select set on purpose: dual port must still be edge
      setup(lcr_pkg::LCR_DUALPORT, 1'h1);
      fab_u.drive(4'h7, 4'h7, 1'h1, 1'h0, 1'h1);
      chk("y_comb", 1'h0, y_comb);
      fab_u.drive(4'h9, 4'h7, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h0, x_comb);
      chk("y_comb", 1'h1, y_comb);
      fab_u.drive(4'h7, 4'h9, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h1, x_comb);
      chk("y_comb", 1'h0, y_comb);
   endtask : t_dualport

   task automatic t_level();
      setup(lcr_pkg::LCR_DUAL16, 1'h1);
      fab_u.drive(4'h4, 4'h6, 1'h1, 1'h1, 1'h1);
      chk("x_comb", 1'h1, x_comb);
      chk("y_comb", 1'h1, y_comb);
      fab_u.drive(4'h4, 4'h6, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h1, x_comb);
      chk("y_comb", 1'h1, y_comb);
   endtask : t_level

   task automatic t_ramlogic();
      logic [4:0] i;
      setup(lcr_pkg::LCR_RAM_LOGIC, 1'h0);
      logic_table_i = 32'h9c35_a6e1;
      fab_u.drive(4'h2, 4'h0, 1'h1, 1'h0, 1'h1);
      fab_u.drive(4'h2, 4'h0, 1'h0, 1'h0, 1'h0);
      chk("x_comb", 1'h1, x_comb);
      // Walk all 32 function inputs while the RAM keeps its bit
      for (int k = 0; k < 32; k++)
      begin
         i = k[4:0];
         fab_u.drive(4'h2, i[3:0], 1'h0, i[4], 1'h0);
         chk("y_comb", logic_table_i[i], y_comb);
         chk("x_comb", 1'h1, x_comb);
      end
   endtask : t_ramlogic

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_n_i       = 1'h0;
      mode_i        = lcr_pkg::LCR_DUAL16;
      level_mode_i  = 1'h0;
      logic_table_i = 32'h0000_0000;
      n_mismatch    = 0;
      num_checks    = 0;
      cyc           = 0;
      t_dual16();
      t_wide32();
      t_dualport();
      t_level();
      t_ramlogic();
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
